// ### verilog/i2c_slave_map.svh
`ifndef I2C_SLAVE_MAP_SVH
`define I2C_SLAVE_MAP_SVH
// ==========================================
// Bit counts and address layout
`define BIT_CNT_W 4
// Start presets one below zero: the first fall after Start carries no bit
`define BIT_PRE_FIRST 4'hf
`define BIT_LAST_DATA 4'h8
`define BIT_ACK 4'h9
`define TEN_HIGH_PATTERN 5'h1e
`define ADDR_TOP_HI 2
`define ADDR_TOP_LO 1
`endif

// ### verilog/i2c_slave_pkg.sv
package i2c_slave_pkg;
    // ==========================================
    // Link-side byte phase
    typedef enum logic [5:0] {
        LK_IDLE = 6'b000001,
        LK_ADDR = 6'b000010,
        LK_TX = 6'b000100,
        LK_RX = 6'b001000,
        LK_ACK = 6'b010000,
        LK_IGNORE = 6'b100000
    } link_state_t;
endpackage

// ### verilog/sync_pulse.sv
`timescale 1ns/10ps
module sync_pulse (
    input wire logic srcClock,
    input wire logic dstClock,
    input wire logic rst_n,
    input wire logic srcPulse,
    output logic dstPulse
);
    // ==========================================
    // Toggle crossing; events closer than a few dst cycles merge
    logic srcToggle;
    logic meta;
    logic stage;
    logic last;

    always_ff @(posedge srcClock or negedge rst_n) begin
        if (!rst_n) begin
            srcToggle <= 1'b0;
        end else if (srcPulse) begin
            srcToggle <= ~srcToggle;
        end
    end

    always_ff @(posedge dstClock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            stage <= 1'b0;
            last <= 1'b0;
            dstPulse <= 1'b0;
        end else begin
            meta <= srcToggle;
            stage <= meta;
            last <= stage;
            dstPulse <= stage ^ last;
        end
    end
endmodule

// ### verilog/i2c_slave_tx.sv
`timescale 1ns/10ps
`include "i2c_slave_map.svh"
module i2c_slave_tx (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclClock,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic sclOut,
    output logic sclOe,
    input wire logic [7:0] ownAddressWrData,
    input wire logic ownAddressWrite,
    input wire logic [7:0] bufferWrData,
    input wire logic bufferWrite,
    input wire logic bufferRead,
    input wire logic clockReleaseSet,
    input wire logic eventFlagClear,
    input wire logic collisionFlagClear,
    input wire logic tenBitMode,
    input wire logic addressHoldEnable,
    input wire logic stretchEnable,
    input wire logic slaveCollisionDetectEnable,
    input wire logic startEventEnable,
    input wire logic ackValueToSend,
    output logic [7:0] receiveTransmitBuffer,
    output logic [7:0] ownAddressRegister,
    output logic clockReleaseBit,
    output logic readWriteFlag,
    output logic ackReceivedStatus,
    output logic serialPortEventFlag,
    output logic busCollisionFlag,
    output logic startSeenFlag,
    output logic bufferFullFlag,
    output logic addressUpdateNeeded,
    output logic ackTimeFlag
);
    // ==========================================
    // Pin sampling on the system clock
    logic sclMeta, sclSync, sclPrev, sdaMeta, sdaSync, sdaPrev;
    logic sclRise, sclFall, startCond, stopCond;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclMeta <= sclClock;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= sdaIn;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    assign sclRise = sclSync & ~sclPrev;
    assign sclFall = ~sclSync & sclPrev;
    assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
    assign stopCond = sclSync & sclPrev & ~sdaPrev & sdaSync;

    // ==========================================
    // Byte engine
    i2c_slave_pkg::link_state_t state;
    logic [`BIT_CNT_W-1:0] bitCount;
    logic [7:0] shiftRegisterStage;
    logic lowPhase;
    logic tenMatched;
    logic ackAssert;
    logic holdPending;
    logic stretchReq;
    logic nextRead;
    logic addrMatch;
    logic [7:0] rxByte;
    logic startPulse;
    logic startEvent;
    logic releaseEvent;

    // Eight bits are complete in the shifter by the eighth fall
    assign rxByte = shiftRegisterStage;
    assign nextRead = rxByte[0];

    // High byte: 11110 A9 A8 R/W, R/W 1 only once tenMatched is set; low byte all eight bits
    always_comb begin
        if (tenBitMode && !lowPhase) begin
            addrMatch = (rxByte[7:3] == `TEN_HIGH_PATTERN)
                && (rxByte[2:1] == ownAddressRegister[`ADDR_TOP_HI:`ADDR_TOP_LO])
                && (!rxByte[0] ? 1'b1 : tenMatched);
        end else if (tenBitMode) begin
            addrMatch = (rxByte == ownAddressRegister);
        end else begin
            addrMatch = (rxByte[7:1] == ownAddressRegister[7:1]);
        end
    end

    // Start detection routed through a toggle crossing for software side
    sync_pulse startCross (
        .srcClock(clock),
        .dstClock(clock),
        .rst_n(rst_n),
        .srcPulse(startCond),
        .dstPulse(startPulse)
    );

    assign startEvent = startPulse;
    assign releaseEvent = clockReleaseSet | (ownAddressWrite & addressUpdateNeeded);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= i2c_slave_pkg::LK_IDLE;
            bitCount <= 4'h0;
            shiftRegisterStage <= 8'h00;
            lowPhase <= 1'b0;
            tenMatched <= 1'b0;
            ackAssert <= 1'b0;
            holdPending <= 1'b0;
            readWriteFlag <= 1'b0;
            ackReceivedStatus <= 1'b0;
            ackTimeFlag <= 1'b0;
            stretchReq <= 1'b0;
        end else if (startCond) begin
            state <= i2c_slave_pkg::LK_ADDR;
            bitCount <= `BIT_PRE_FIRST;
            lowPhase <= 1'b0;
            ackAssert <= 1'b0;
        end else if (stopCond) begin
            state <= i2c_slave_pkg::LK_IDLE;
            ackAssert <= 1'b0;
            tenMatched <= 1'b0;
        end else if (bufferWrite) begin
            shiftRegisterStage <= bufferWrData;
        end else if (sclRise && state != i2c_slave_pkg::LK_IDLE) begin
            if (bitCount == `BIT_LAST_DATA && state == i2c_slave_pkg::LK_ACK && readWriteFlag) begin
                ackReceivedStatus <= sdaSync;
            end else if (bitCount < `BIT_LAST_DATA && state != i2c_slave_pkg::LK_TX) begin
                shiftRegisterStage <= {shiftRegisterStage[6:0], sdaSync};
            end
        end else if (sclFall) begin
            case (state)
                i2c_slave_pkg::LK_ADDR,
                i2c_slave_pkg::LK_RX: begin
                    bitCount <= bitCount + 4'h1;
                    if (bitCount + 4'h1 == `BIT_LAST_DATA) begin
                        state <= i2c_slave_pkg::LK_ACK;
                        if (state == i2c_slave_pkg::LK_ADDR) begin
                            if (addrMatch) begin
                                readWriteFlag <= shiftRegisterStage[0];
                                ackTimeFlag <= addressHoldEnable;
                                holdPending <= addressHoldEnable;
                                stretchReq <= addressHoldEnable;
                                ackAssert <= !addressHoldEnable;
                                if (tenBitMode && lowPhase) begin
                                    tenMatched <= 1'b1;
                                end
                            end else if (tenBitMode && lowPhase) begin
                                ackAssert <= 1'b0;
                            end else begin
                                state <= i2c_slave_pkg::LK_IGNORE;
                            end
                        end else begin
                            ackAssert <= 1'b1;
                        end
                    end
                end
                i2c_slave_pkg::LK_TX: begin
                    bitCount <= bitCount + 4'h1;
                    shiftRegisterStage <= {shiftRegisterStage[6:0], 1'b0};
                    if (bitCount + 4'h1 == `BIT_LAST_DATA) begin
                        state <= i2c_slave_pkg::LK_ACK;
                    end
                    if (slaveCollisionDetectEnable && shiftRegisterStage[7] && !sdaSync) begin
                        state <= i2c_slave_pkg::LK_IDLE;
                    end
                end
                i2c_slave_pkg::LK_ACK: begin
                    begin
                        bitCount <= 4'h0;
                        ackAssert <= 1'b0;
                        ackTimeFlag <= 1'b0;
                        // In hold mode our own NACK ends the read as well
                        if (readWriteFlag && (holdPending ? !ackAssert : ackReceivedStatus)) begin
                            state <= i2c_slave_pkg::LK_IDLE;
                        end else if (readWriteFlag) begin
                            state <= i2c_slave_pkg::LK_TX;
                            stretchReq <= 1'b1;
                        end else begin
                            state <= i2c_slave_pkg::LK_RX;
                            stretchReq <= stretchEnable;
                            if (tenBitMode && !tenMatched) begin
                                lowPhase <= 1'b1;
                                state <= i2c_slave_pkg::LK_ADDR;
                            end else begin
                                lowPhase <= 1'b0;
                            end
                        end
                        holdPending <= 1'b0;
                    end
                end
                default: begin
                    bitCount <= bitCount;
                end
            endcase
        end else if (releaseEvent && holdPending) begin
            ackAssert <= !ackValueToSend;
            stretchReq <= 1'b0;
        end else if (releaseEvent) begin
            stretchReq <= 1'b0;
        end else if (state == i2c_slave_pkg::LK_IGNORE) begin
            state <= i2c_slave_pkg::LK_IGNORE;
        end
    end

    // ==========================================
    // Clock release bit and address-update stretch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clockReleaseBit <= 1'b1;
        end else if (sclFall && state == i2c_slave_pkg::LK_ACK && bitCount == `BIT_LAST_DATA
                     && (readWriteFlag ? (holdPending ? ackAssert : !ackReceivedStatus) : stretchEnable)) begin
            clockReleaseBit <= 1'b0;
        end else if (sclFall && state == i2c_slave_pkg::LK_ADDR && bitCount + 4'h1 == `BIT_LAST_DATA
                     && addrMatch && addressHoldEnable) begin
            clockReleaseBit <= 1'b0;
        end else if (clockReleaseSet) begin
            clockReleaseBit <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            addressUpdateNeeded <= 1'b0;
            ownAddressRegister <= 8'h00;
        end else if (ownAddressWrite) begin
            ownAddressRegister <= ownAddressWrData;
            addressUpdateNeeded <= 1'b0;
        end else if (sclFall && state == i2c_slave_pkg::LK_ACK && bitCount == `BIT_LAST_DATA
                     && tenBitMode && !readWriteFlag && (!tenMatched || lowPhase)) begin
            addressUpdateNeeded <= 1'b1;
        end
    end

    // ==========================================
    // Buffer and flags; hardware set wins over software clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            receiveTransmitBuffer <= 8'h00;
            bufferFullFlag <= 1'b0;
        end else if (bufferWrite) begin
            receiveTransmitBuffer <= bufferWrData;
            bufferFullFlag <= 1'b1;
        end else if (sclFall && state == i2c_slave_pkg::LK_ADDR && bitCount + 4'h1 == `BIT_LAST_DATA
                     && addrMatch) begin
            receiveTransmitBuffer <= rxByte;
            bufferFullFlag <= 1'b1;
        end else if (sclFall && state == i2c_slave_pkg::LK_RX && bitCount + 4'h1 == `BIT_LAST_DATA) begin
            receiveTransmitBuffer <= rxByte;
            bufferFullFlag <= 1'b1;
        end else if (bufferRead) begin
            bufferFullFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            serialPortEventFlag <= 1'b0;
        end else if (sclFall && state == i2c_slave_pkg::LK_ACK && bitCount == `BIT_LAST_DATA) begin
            serialPortEventFlag <= 1'b1;
        end else if (sclFall && state == i2c_slave_pkg::LK_ADDR && bitCount + 4'h1 == `BIT_LAST_DATA
                     && addrMatch && addressHoldEnable) begin
            serialPortEventFlag <= 1'b1;
        end else if (startEvent && startEventEnable && state == i2c_slave_pkg::LK_ADDR) begin
            serialPortEventFlag <= 1'b1;
        end else if (eventFlagClear) begin
            serialPortEventFlag <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            startSeenFlag <= 1'b0;
            busCollisionFlag <= 1'b0;
        end else begin
            if (startEvent) begin
                startSeenFlag <= 1'b1;
            end else if (stopCond) begin
                startSeenFlag <= 1'b0;
            end
            if (sclFall && state == i2c_slave_pkg::LK_TX && slaveCollisionDetectEnable
                && shiftRegisterStage[7] && !sdaSync) begin
                busCollisionFlag <= 1'b1;
            end else if (collisionFlagClear) begin
                busCollisionFlag <= 1'b0;
            end
        end
    end

    // ==========================================
    // Open-drain pins: enable low means pulling low
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sdaOut <= 1'b0;
            sdaOe <= 1'b1;
            sclOut <= 1'b0;
            sclOe <= 1'b1;
        end else begin
            sdaOut <= 1'b0;
            sclOut <= 1'b0;
            if (state == i2c_slave_pkg::LK_ACK && bitCount == `BIT_LAST_DATA) begin
                sdaOe <= ~ackAssert;
            end else if (state == i2c_slave_pkg::LK_TX) begin
                sdaOe <= shiftRegisterStage[7];
            end else begin
                sdaOe <= 1'b1;
            end
            // Only hold once the master has pulled low, so high time is never cut
            sclOe <= ~(!sclSync && (stretchReq || addressUpdateNeeded));
        end
    end
endmodule

// ### sim/i2c_slave_tx_assertions.sv
`timescale 1ns/10ps
module i2c_slave_tx_assertions (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sclClock,
    input wire logic sdaOut,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic [7:0] bufferWrData,
    input wire logic bufferWrite,
    input wire logic bufferRead,
    input wire logic clockReleaseSet,
    input wire logic eventFlagClear,
    input wire logic ownAddressWrite,
    input wire logic slaveCollisionDetectEnable,
    input wire logic [7:0] receiveTransmitBuffer,
    input wire logic clockReleaseBit,
    input wire logic serialPortEventFlag,
    input wire logic busCollisionFlag,
    input wire logic bufferFullFlag,
    input wire logic addressUpdateNeeded
);
    // ==========================================
    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_od; sdaOut == 1'b0 && sclOut == 1'b0; endproperty
    a_od: assert property (p_od) else $error("pin driven high");
    property p_full; bufferWrite |=> bufferFullFlag; endproperty
    a_full: assert property (p_full) else $error("full flag not set");
    property p_load; bufferWrite |=> receiveTransmitBuffer == $past(bufferWrData); endproperty
    a_load: assert property (p_load) else $error("buffer not loaded");
    property p_empty; bufferRead && !bufferWrite |=> !bufferFullFlag; endproperty
    a_empty: assert property (p_empty) else $error("full flag not cleared");
    property p_rel; clockReleaseSet && !addressUpdateNeeded |-> ##[1:3] sclOe; endproperty
    a_rel: assert property (p_rel) else $error("clock not released");
    // Only a line already low is held, so high time is never cut short
    property p_hold; ((!clockReleaseBit || addressUpdateNeeded) && !sclClock) [*6] |-> !sclOe; endproperty
    a_hold: assert property (p_hold) else $error("clock not stretched");
    property p_low; $fell(sclOe) |-> !sclClock; endproperty
    a_low: assert property (p_low) else $error("clock grabbed while high");
    property p_bcl; $rose(busCollisionFlag) |-> slaveCollisionDetectEnable; endproperty
    a_bcl: assert property (p_bcl) else $error("collision flag while disabled");
    property p_ev; serialPortEventFlag && !eventFlagClear |=> serialPortEventFlag; endproperty
    a_ev: assert property (p_ev) else $error("event flag lost");
    property p_ua;
        addressUpdateNeeded && ownAddressWrite && clockReleaseBit |-> ##[1:3] (!addressUpdateNeeded && sclOe);
    endproperty
    a_ua: assert property (p_ua) else $error("address write did not release");
endmodule
bind i2c_slave_tx i2c_slave_tx_assertions i2c_slave_tx_assertions_inst (.clock, .rst_n, .sclClock, .sdaOut,
    .sclOut, .sclOe, .bufferWrData, .bufferWrite, .bufferRead, .clockReleaseSet, .eventFlagClear,
    .ownAddressWrite, .slaveCollisionDetectEnable, .receiveTransmitBuffer, .clockReleaseBit,
    .serialPortEventFlag, .busCollisionFlag, .bufferFullFlag, .addressUpdateNeeded);

// ### sim/i2c_master.sv
`timescale 1ns/10ps
module i2c_master (
    input wire logic sclLine,
    input wire logic sdaLine,
    output logic mScl,
    output logic mSda
);
    // ==========================================
    // Bus master, 80 ns bit, SCL idle high between frames
    initial begin
        mScl = 1'b1;
        mSda = 1'b1;
    end
    task automatic clk(input logic d, output logic q);
        mScl = 1'b0;
        #20 mSda = d;
        #20 mScl = 1'b1;
        // Bounded wait while a slave holds SCL low
        for (int n = 0; n < 4000 && !sclLine; n++) #5;
        #20 q = sdaLine;
        #20;
    endtask
    task automatic start;
        mSda = 1'b1;
        #20 mScl = 1'b1;
        #40 mSda = 1'b0;
        #40;
    endtask
    task automatic stop;
        mScl = 1'b0;
        #20 mSda = 1'b0;
        #20 mScl = 1'b1;
        #40 mSda = 1'b1;
        #40;
    endtask
    task automatic wr(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) clk(b[i], q);
        clk(1'b1, ack);
        mScl = 1'b0;
        #40;
    endtask
    // Clash pulls SDA low against the slave's data
    task automatic rd(input logic nack, input logic clash, output logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            clk(!clash, q);
            b[i] = q;
        end
        clk(nack, q);
        mScl = 1'b0;
        #40;
    endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
module tb;
    // ==========================================
    // Signals
    logic clock;
    logic rst_n = 1'b0;
    logic [7:0] wrData = 8'h00;
    logic [5:0] pulses = 6'h00;
    logic tenBitMode = 1'b0, addressHoldEnable = 1'b0, stretchEnable = 1'b0;
    logic slaveCollisionDetectEnable = 1'b0, startEventEnable = 1'b0, ackValueToSend = 1'b0;
    logic ownAddressWrite, bufferWrite, bufferRead, clockReleaseSet, eventFlagClear, collisionFlagClear;
    logic sdaOut, sdaOe, sclOut, sclOe, mScl, mSda, ack;
    logic [7:0] receiveTransmitBuffer, ownAddressRegister, got;
    logic clockReleaseBit, readWriteFlag, ackReceivedStatus, serialPortEventFlag, busCollisionFlag;
    logic startSeenFlag, bufferFullFlag, addressUpdateNeeded, ackTimeFlag;
    int num_errors = 0;
    int checks = 0;
    localparam int OAW = 5, BW = 4, BR = 3, CR = 2, EC = 1, CC = 0;
    // Pull-ups: a released line reads high
    wire sclLine = mScl & sclOe;
    wire sdaLine = mSda & sdaOe;
    assign {ownAddressWrite, bufferWrite, bufferRead, clockReleaseSet, eventFlagClear, collisionFlagClear} = pulses;
    i2c_slave_tx i2c_slave_tx_inst (.clock, .rst_n, .sclClock(sclLine), .sdaIn(sdaLine), .sdaOut, .sdaOe, .sclOut,
        .sclOe, .ownAddressWrData(wrData), .ownAddressWrite, .bufferWrData(wrData), .bufferWrite, .bufferRead,
        .clockReleaseSet, .eventFlagClear, .collisionFlagClear, .tenBitMode, .addressHoldEnable, .stretchEnable,
        .slaveCollisionDetectEnable, .startEventEnable, .ackValueToSend, .receiveTransmitBuffer,
        .ownAddressRegister, .clockReleaseBit, .readWriteFlag, .ackReceivedStatus, .serialPortEventFlag,
        .busCollisionFlag, .startSeenFlag, .bufferFullFlag, .addressUpdateNeeded, .ackTimeFlag);
    i2c_master i2c_master_inst (.sclLine, .sdaLine, .mScl, .mSda);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // ==========================================
    // Tasks
    task chkBit(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: bit %b expected %b", $time, g, e);
        end
    endtask
    task chkByte(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch at %0t: byte %h expected %h", $time, g, e);
        end
    endtask
    task sw(input int i, input logic [7:0] d);
        @(negedge clock) wrData = d;
        pulses[i] = 1'b1;
        @(negedge clock) pulses = 6'h00;
    endtask
    task waitEv;
        for (int n = 0; n < 2000 && serialPortEventFlag !== 1'b1; n++) @(negedge clock);
        @(negedge clock);
    endtask
    task txByte(input logic [7:0] d, input logic nack, input logic clash);
        fork
            i2c_master_inst.rd(nack, clash, got);
            begin
                sw(BW, d);
                chkBit(bufferFullFlag, 1'b1);
                sw(CR, d);
            end
        join
    endtask
    task close_out;
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out;
    end
    // ==========================================
    // Tests
    initial begin
        repeat (8) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        repeat (2) @(negedge clock);
        chkBit(clockReleaseBit, 1'b1);
        chkBit(sclOe & sdaOe, 1'b1);
        chkByte(ownAddressRegister, 8'h00);
        sw(OAW, 8'ha4);
        i2c_master_inst.start;
        chkBit(startSeenFlag, 1'b1);
        chkBit(serialPortEventFlag, 1'b0);
        i2c_master_inst.wr(8'h43, ack);
        chkBit(ack, 1'b1);
        chkBit(serialPortEventFlag, 1'b0);
        i2c_master_inst.stop;
        i2c_master_inst.start;
        i2c_master_inst.wr(8'ha5, ack);
        chkBit(ack, 1'b0);
        chkBit(readWriteFlag, 1'b1);
        chkByte(receiveTransmitBuffer, 8'ha5);
        chkBit(clockReleaseBit | sclOe, 1'b0);
        chkBit(serialPortEventFlag, 1'b1);
        sw(EC, 8'h00);
        sw(BR, 8'h00);
        chkBit(bufferFullFlag, 1'b0);
        txByte(8'h5a, 1'b0, 1'b0);
        chkByte(got, 8'h5a);
        chkBit(ackReceivedStatus, 1'b0);
        chkBit(clockReleaseBit | sclOe, 1'b0);
        chkBit(serialPortEventFlag, 1'b1);
        sw(EC, 8'h00);
        txByte(8'h81, 1'b1, 1'b0);
        chkByte(got, 8'h81);
        chkBit(ackReceivedStatus, 1'b1);
        chkBit(sclOe, 1'b1);
        chkBit(serialPortEventFlag, 1'b1);
        i2c_master_inst.stop;
        addressHoldEnable = 1'b1;
        startEventEnable = 1'b1;
        for (int v = 1; v >= 0; v--) begin
            sw(EC, 8'h00);
            i2c_master_inst.start;
            chkBit(serialPortEventFlag, 1'b1);
            sw(EC, 8'h00);
            fork
                i2c_master_inst.wr(8'ha5, ack);
                begin
                    waitEv;
                    chkBit(clockReleaseBit | sclOe, 1'b0);
                    ackValueToSend = v[0];
                    sw(EC, 8'h00);
                    sw(BR, 8'h00);
                    sw(CR, 8'h00);
                end
            join
            chkBit(ack, v[0]);
            if (v == 0) begin
                chkBit(clockReleaseBit, 1'b0);
                chkBit(serialPortEventFlag, 1'b1);
                sw(EC, 8'h00);
                txByte(8'hc3, 1'b1, 1'b0);
                chkByte(got, 8'hc3);
            end
            i2c_master_inst.stop;
        end
        addressHoldEnable = 1'b0;
        startEventEnable = 1'b0;
        slaveCollisionDetectEnable = 1'b1;
        i2c_master_inst.start;
        i2c_master_inst.wr(8'ha5, ack);
        sw(BR, 8'h00);
        txByte(8'hff, 1'b1, 1'b1);
        chkBit(busCollisionFlag, 1'b1);
        sw(CC, 8'h00);
        chkBit(busCollisionFlag, 1'b0);
        i2c_master_inst.stop;
        slaveCollisionDetectEnable = 1'b0;
        tenBitMode = 1'b1;
        sw(OAW, 8'hf6);
        for (int m = 0; m < 2; m++) begin
            sw(EC, 8'h00);
            i2c_master_inst.start;
            i2c_master_inst.wr(8'hf6, ack);
            chkBit(ack, 1'b0);
            chkBit(addressUpdateNeeded & serialPortEventFlag, 1'b1);
            chkBit(clockReleaseBit & !sclOe, 1'b1);
            sw(EC, 8'h00);
            sw(BR, 8'h00);
            fork
                i2c_master_inst.wr(m ? 8'h3c : 8'h3d, ack);
                sw(OAW, 8'h3c);
            join
            chkBit(ack, m ? 1'b0 : 1'b1);
            chkBit(addressUpdateNeeded & serialPortEventFlag & clockReleaseBit, 1'b1);
            chkBit(bufferFullFlag, m ? 1'b1 : 1'b0);
            sw(EC, 8'h00);
            sw(BR, 8'h00);
            stretchEnable = m[0];
            if (m == 0) sw(OAW, 8'hf6);
            else begin
                fork
                    i2c_master_inst.wr(8'h5a, ack);
                    sw(OAW, 8'hf6);
                join
                chkByte(receiveTransmitBuffer, 8'h5a);
                chkBit(clockReleaseBit | sclOe, 1'b0);
                sw(CR, 8'h00);
            end
            i2c_master_inst.stop;
        end
        close_out;
    end
endmodule
